// ### logic/spifr_consts.svh
// constants of the serial EEPROM command front: opcodes, status layout, timing
`ifndef SPIFR_CONSTS_SVH
`define SPIFR_CONSTS_SVH

// ****************************************************************
// instruction opcodes
// ****************************************************************
`define SPIFR_OP_SET_LATCH 8'h06
`define SPIFR_OP_CLR_LATCH 8'h04
`define SPIFR_OP_STAT_RD 8'h05
`define SPIFR_OP_STAT_WR 8'h01
`define SPIFR_OP_MEM_RD 8'h03
`define SPIFR_OP_MEM_WR 8'h02

// ****************************************************************
// status byte field positions and reset values
// ****************************************************************
`define SPIFR_ST_LOCK 7
`define SPIFR_ST_PS_HI 3
`define SPIFR_ST_PS_LO 2
`define SPIFR_ST_LATCH 1
`define SPIFR_ST_BUSY 0
`define SPIFR_NV_LOCK_RST 1'h0
`define SPIFR_NV_PS_RST 2'h0

// ****************************************************************
// frame lengths in serial bits
// ****************************************************************
`define SPIFR_BITS_OPCODE 6'h08
`define SPIFR_BITS_STAT_WR 6'h10
`define SPIFR_BITS_MEM_WR 6'h20
`define SPIFR_BITS_SAT 6'h3F

// ****************************************************************
// self-timed cycle: 5 ms at an 8 ns clock
// ****************************************************************
`define SPIFR_WRITE_TIME_NS 5000000
`define SPIFR_CLK_PERIOD_NS 8
`define SPIFR_WRITE_CYCLES (`SPIFR_WRITE_TIME_NS / `SPIFR_CLK_PERIOD_NS)
`define SPIFR_TIMER_W 24

`endif

// ### logic/spifr_pkg.sv
// types shared by the serial EEPROM command front
package spifr_pkg;

   // status byte as seen by the host
   typedef struct packed {
      logic lock;
      logic [2:0] rsvd;
      logic ps_hi;
      logic ps_lo;
      logic latch;
      logic busy;
   } spifr_status_t;

   // everything the serial side has gathered in one frame
   typedef struct packed {
      logic toggle;
      logic dead;
      logic [2:0] bpos;
      logic [5:0] nbits;
      logic [7:0] shift;
      logic [7:0] opcode;
      logic [7:0] data;
      logic [15:0] addr;
   } spifr_frame_t;

   // output shifter on the falling serial edge
   typedef struct packed {
      logic on;
      logic so;
      logic [7:0] sh;
   } spifr_tx_t;

   // control state in the system clock domain
   typedef struct packed {
      logic cs_q;
      logic armed;
      logic tog_seen;
      logic busy;
      logic latch;
      logic lock;
      logic [1:0] ps;
      logic nv_lock;
      logic [1:0] nv_ps;
      logic status_write_cmd_cyc;
      logic standby;
      logic [23:0] timer;
   } spifr_ctl_t;

endpackage

// ### logic/spifr_sync.sv
// two-flop level synchroniser with clock enable
`timescale 1ns/1ps
module spifr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic en_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // stage 0 is metastable, only stage 1 reads it
   logic [1:0][W-1:0] st_r;
   logic [1:0][W-1:0] st_nxt;

   // shift one stage per enabled edge
   always_comb begin
      st_nxt = st_r;
      if (en_i) begin
         st_nxt[0] = d_i;
         st_nxt[1] = st_r[0];
      end
   end

   // registered copy
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r <= {RST, RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q_o = st_r[1];
endmodule

// ### logic/spifr_front.sv
// serial EEPROM command front: opcode decode, status register, protection
`timescale 1ns/1ps
`include "spifr_consts.svh"
module spifr_front #(
   parameter int unsigned WRITE_CYCLES = `SPIFR_WRITE_CYCLES,
   parameter int ADDR_W = 15
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   input wire logic hold_n_i,
   input wire logic protect_n_i,
   output spifr_pkg::spifr_status_t status_o,
   output logic hw_lock_o,
   output logic standby_o
);
   import spifr_pkg::*;

   // ****************************************************************
   // declarations
   // ****************************************************************
   localparam logic [`SPIFR_TIMER_W-1:0] TMR_LOAD = `SPIFR_TIMER_W'(WRITE_CYCLES - 1);

   spifr_frame_t fr_r;
   spifr_frame_t fr_nxt;
   spifr_tx_t tx_r;
   spifr_tx_t tx_nxt;
   spifr_ctl_t ctl_r;
   spifr_ctl_t ctl_nxt;
   spifr_status_t stat_now;
   spifr_status_t stat_link;
   logic frame_start_r;
   logic link_set;
   logic armed_link;
   logic cs_s;
   logic protect_s;
   logic cs_rise;
   logic cs_fall;
   logic frame_new;
   logic hardware_lock_mode;
   logic rd_act;
   logic [5:0] cnt;
   logic [7:0] sh_in;

   // opcode is one of the six known instructions
   function automatic logic op_known(input logic [7:0] op);
      op_known = (op == `SPIFR_OP_SET_LATCH) || (op == `SPIFR_OP_CLR_LATCH) ||
                 (op == `SPIFR_OP_STAT_RD) || (op == `SPIFR_OP_STAT_WR) ||
                 (op == `SPIFR_OP_MEM_RD) || (op == `SPIFR_OP_MEM_WR);
   endfunction

   // address falls in the block chosen by the protect size
   function automatic logic in_protected(input logic [1:0] ps, input logic [15:0] a);
      in_protected = 1'b0;
      unique case (ps)
         2'h0: in_protected = 1'b0;
         2'h1: in_protected = (a[ADDR_W-1 -: 2] == 2'h3);
         2'h2: in_protected = a[ADDR_W-1];
         2'h3: in_protected = 1'b1;
      endcase
   endfunction

   // ****************************************************************
   // serial receive side, runs on the host's serial clock
   // ****************************************************************

   // chip enable high marks the next rising edge as bit one of a frame;
   // only this flag is touched while the clock stands still, so the
   // frame contents survive deselect for the control side to read
   assign link_set = cs_n_i | ~resetn_i;

   always_ff @(posedge sclk_i or posedge link_set) begin
      if (link_set) begin
         frame_start_r <= 1'b1;
      end else if (hold_n_i) begin
         frame_start_r <= 1'b0;
      end
   end

   // bit counting and byte capture
   always_comb begin
      fr_nxt = fr_r;
      cnt = frame_start_r ? 6'h00 : fr_r.nbits;
      sh_in = frame_start_r ? {7'h00, si_i} : {fr_r.shift[6:0], si_i};
      if (hold_n_i && (frame_start_r || !fr_r.dead)) begin
         if (frame_start_r) begin
            fr_nxt.toggle = ~fr_r.toggle;
            fr_nxt.dead = 1'b0;
            fr_nxt.bpos = 3'h1;
         end else begin
            fr_nxt.bpos = fr_r.bpos + 3'h1;
         end
         fr_nxt.shift = sh_in;
         // the count saturates so an endless read cannot wrap into a short frame
         fr_nxt.nbits = (cnt == `SPIFR_BITS_SAT) ? cnt : cnt + 6'h01;
         if (cnt == 6'h07) begin
            fr_nxt.opcode = sh_in;
            // unknown opcode kills frame
            // a killed frame keeps its counters frozen until the next select
            fr_nxt.dead = !op_known(sh_in);
         end
         if (cnt == 6'h0F) begin
            fr_nxt.data = sh_in;
            fr_nxt.addr[15:8] = sh_in;
         end
         if (cnt == 6'h17) begin
            fr_nxt.addr[7:0] = sh_in;
         end
      end
   end

   // receive registers, reset only at power-up
   // deselect leaves them alone: the control side reads them afterwards
   always_ff @(posedge sclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fr_r <= '0;
      end else begin
         fr_r <= fr_nxt;
      end
   end

   // ****************************************************************
   // serial transmit side, falling serial clock edge
   // ****************************************************************

   // status and the power-up arming level come over from the control
   // side; each bit is an independent flag, so per-bit sync is enough
   // the two-edge lag ends long before an opcode byte is complete
   spifr_sync #(
      .W(9),
      .RST(9'h000)
   ) u_link_sync (
      .clk_i(sclk_i),
      .resetn_i(resetn_i),
      .en_i(1'b1),
      .d_i({ctl_r.armed, stat_now}),
      .q_o({armed_link, stat_link})
   );

   // status read opcode; unarmed device stays silent
   assign rd_act = !frame_start_r && !fr_r.dead && (fr_r.opcode == `SPIFR_OP_STAT_RD) &&
                   (fr_r.nbits >= `SPIFR_BITS_OPCODE) && armed_link;

   always_comb begin
      tx_nxt = tx_r;
      if (hold_n_i) begin
         // the shifter idles whenever no status read is decoded
         tx_nxt.on = rd_act;
         // reload status on every byte boundary
         if (rd_act && (fr_r.bpos == 3'h0)) begin
            tx_nxt.so = stat_link[7];
            tx_nxt.sh = {stat_link[6:0], 1'b0};
         end else if (rd_act) begin
            tx_nxt.so = tx_r.sh[7];
            tx_nxt.sh = {tx_r.sh[6:0], 1'b0};
         end
      end
   end

   always_ff @(negedge sclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_r <= '0;
      end else begin
         tx_r <= tx_nxt;
      end
   end

   assign so_o = tx_r.so;
   // deselect tri-states; pause tri-states; the enable is also
   // gated by the live read decode, since the shifter keeps its last
   // state across deselect and would drive for half a bit at the next
   // frame's first rising edge; rd_act already excludes that edge
   assign so_oe_o = tx_r.on & rd_act & ~cs_n_i & hold_n_i;

   // ****************************************************************
   // control side, system clock
   // ****************************************************************

   // chip enable and protect pin enter through two flops; the select
   // stage resets low so that a pin already low at power-up shows no
   // edge at all, the protect stage resets high, the unlocked level
   spifr_sync #(
      .W(2),
      .RST(2'h1)
   ) u_pin_sync (
      .clk_i(clock_i),
      .resetn_i(resetn_i),
      .en_i(ce_i),
      .d_i({cs_n_i, protect_n_i}),
      .q_o({cs_s, protect_s})
   );

   assign cs_rise = cs_s & ~ctl_r.cs_q;
   assign cs_fall = ~cs_s & ctl_r.cs_q;
   // lock bit with protect pin low
   assign hardware_lock_mode = ctl_r.lock & ~protect_s;

   // a frame is new once its toggle differs from the last one consumed;
   // its fields are quiet here because the serial clock has stopped
   assign frame_new = cs_rise & (fr_r.toggle != ctl_r.tog_seen);

   // status byte layout; reserved bits zero
   always_comb begin
      stat_now = '0;
      stat_now.lock = ctl_r.lock;
      stat_now.ps_hi = ctl_r.ps[1];
      stat_now.ps_lo = ctl_r.ps[0];
      stat_now.latch = ctl_r.latch;
      stat_now.busy = ctl_r.busy;
   end

   // frame results are read only after the synchronised deselect, when
   // the serial clock has stopped, so the frame fields are quiet
   always_comb begin
      ctl_nxt = ctl_r;
      ctl_nxt.cs_q = cs_s;
      if (cs_fall) begin
         ctl_nxt.armed = 1'b1;
      end
      // busy counts the self-timed cycle
      // the timer moves only on enabled cycles, so a held enable stretches it
      if (ctl_r.busy) begin
         if (ctl_r.timer == '0) begin
            ctl_nxt.busy = 1'b0;
            ctl_nxt.latch = 1'b0;
            if (ctl_r.status_write_cmd_cyc) begin
               ctl_nxt.lock = ctl_r.nv_lock;
               ctl_nxt.ps = ctl_r.nv_ps;
            end
         end else begin
            ctl_nxt.timer = ctl_r.timer - `SPIFR_TIMER_W'(1);
         end
      end
      // empty frames leave the toggle untouched and are skipped; a frame
      // sent before arming is consumed too, or the next one looks empty
      if (frame_new) begin
         ctl_nxt.tog_seen = fr_r.toggle;
      end
      // nothing executes before the first select edge
      if (frame_new && ctl_r.armed) begin
         if (!fr_r.dead && (fr_r.nbits == `SPIFR_BITS_OPCODE)) begin
            // latch set only here; set beats completion clear
            if (fr_r.opcode == `SPIFR_OP_SET_LATCH) begin
               ctl_nxt.latch = 1'b1;
            end
            if (fr_r.opcode == `SPIFR_OP_CLR_LATCH) begin
               ctl_nxt.latch = 1'b0;
            end
         end
         // deselect right after the 16th bit
         if (!fr_r.dead && (fr_r.opcode == `SPIFR_OP_STAT_WR) &&
             (fr_r.nbits == `SPIFR_BITS_STAT_WR)) begin
            // latch, idle and no lock mode
            if (ctl_r.latch && !ctl_r.busy && !hardware_lock_mode) begin
               ctl_nxt.busy = 1'b1;
               ctl_nxt.status_write_cmd_cyc = 1'b1;
               ctl_nxt.timer = TMR_LOAD;
               // only lock and size bits taken
               ctl_nxt.nv_lock = fr_r.data[`SPIFR_ST_LOCK];
               ctl_nxt.nv_ps = {fr_r.data[`SPIFR_ST_PS_HI], fr_r.data[`SPIFR_ST_PS_LO]};
            end
         end
         // memory write must end on a byte boundary past one data byte
         if (!fr_r.dead && (fr_r.opcode == `SPIFR_OP_MEM_WR) &&
             (fr_r.nbits >= `SPIFR_BITS_MEM_WR) && (fr_r.bpos == 3'h0)) begin
            // refuse busy, unlatched or protected page
            if (ctl_r.latch && !ctl_r.busy && !in_protected(ctl_r.ps, fr_r.addr)) begin
               ctl_nxt.busy = 1'b1;
               ctl_nxt.status_write_cmd_cyc = 1'b0;
               ctl_nxt.timer = TMR_LOAD;
            end
         end
      end
      // standby when deselected and idle
      // a running cycle keeps the device active after deselect
      ctl_nxt.standby = cs_s & ~ctl_nxt.busy;
   end

   // control registers; lock and size reset to delivery state
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctl_r <= '0;
         // no select seen yet: a pin held low through power-up must not
         // count as the falling edge that arms the device
         ctl_r.cs_q <= 1'b0;
         ctl_r.lock <= `SPIFR_NV_LOCK_RST;
         ctl_r.ps <= `SPIFR_NV_PS_RST;
         ctl_r.nv_lock <= `SPIFR_NV_LOCK_RST;
         ctl_r.nv_ps <= `SPIFR_NV_PS_RST;
         ctl_r.standby <= 1'b1;
      end else if (ce_i) begin
         ctl_r <= ctl_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign status_o = stat_now;
   // lock mode follows the synchronised pin, two enabled cycles late
   assign hw_lock_o = hardware_lock_mode;
   // registered so standby never glitches on a pin edge
   assign standby_o = ctl_r.standby;

endmodule

// ### verification/spifr_front_properties.sv
// assertion checker bound to the serial EEPROM command front
`timescale 1ns/1ps
module spifr_props #(
   parameter int unsigned WRITE_CYCLES = 400
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic so_o,
   input wire logic so_oe_o,
   input wire logic hold_n_i,
   input wire logic protect_n_i,
   input wire spifr_pkg::spifr_status_t status_o,
   input wire logic hw_lock_o,
   input wire logic standby_o
);
   import spifr_pkg::*;
   logic [23:0] busy_cnt_r, busy_cnt_nxt;
   default clocking dclk @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);
   // ********
   // busy stretch length
   // ********
   // restarts at zero whenever busy is low; frozen cycles do not count
   always_comb begin
      busy_cnt_nxt = status_o.busy ? busy_cnt_r + {23'h000000, ce_i} : 24'h000000;
   end
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         busy_cnt_r <= 24'h000000;
      end else begin
         busy_cnt_r <= busy_cnt_nxt;
      end
   end
   // ********
   // assertions
   // ********
   oe_cs_off_a: assert property (cs_n_i |-> !so_oe_o)
      else $error("output driven while deselected");
   oe_hold_off_a: assert property (!hold_n_i |-> !so_oe_o)
      else $error("output driven while paused");
   standby_sel_a: assert property ((!cs_n_i) [*4] |-> !standby_o)
      else $error("standby while selected");
   rsvd_zero_a: assert property (status_o.rsvd == 3'h0)
      else $error("reserved status bits not zero");
   lock_mode_on_a: assert property (
      (ce_i && status_o.lock && !protect_n_i) [*3] |-> hw_lock_o)
      else $error("lock mode missing");
   lock_needs_bit_a: assert property (hw_lock_o |-> status_o.lock)
      else $error("lock mode without lock bit");
   busy_len_a: assert property ($fell(status_o.busy) |->
      busy_cnt_r >= WRITE_CYCLES - 1 && busy_cnt_r <= WRITE_CYCLES + 1)
      else $error("busy stretch length wrong");
   latch_end_a: assert property ($fell(status_o.busy) |-> ##[0:1] !status_o.latch)
      else $error("latch kept after write cycle");
   nv_frozen_a: assert property (status_o.busy && $past(status_o.busy) |->
      $stable({status_o.lock, status_o.ps_hi, status_o.ps_lo}))
      else $error("protection bits moved during cycle");
   nv_change_a: assert property (
      $changed({status_o.lock, status_o.ps_hi, status_o.ps_lo}) |-> $past(status_o.busy))
      else $error("protection bits changed outside a cycle");
endmodule

bind spifr_front spifr_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_props (.clock_i, .resetn_i,
   .ce_i, .sclk_i, .cs_n_i, .si_i, .so_o, .so_oe_o, .hold_n_i, .protect_n_i, .status_o,
   .hw_lock_o, .standby_o);

// ### verification/spifr_host.sv
// host serial master model for the command front's link pins
`timescale 1ns/1ps
module spifr_host (
   input wire logic so_i,
   input wire logic so_oe_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic si_o,
   output logic hold_n_o
);
   logic oe_seen;
   // select low from power-up, so the first frame lacks a falling edge
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b0;
      si_o = 1'b0;
      hold_n_o = 1'b1;
      oe_seen = 1'b0;
   end
   // ********
   // frame engine, clock idles low between frames
   // ********
   // msb first, pause only when selected, deselect before next rise
   task automatic xfer(input logic [31:0] tx, input int nb, input int h,
      output logic [31:0] rx);
      rx = '0;
      oe_seen = 1'b0;
      cs_n_o = 1'b0;
      #48;
      for (int i = nb - 1; i >= 0; i--) begin
         // pause edges sit mid low phase, clear of the shifting falling edge
         if (i == h) begin
            #12 hold_n_o = 1'b0;
            repeat (2) begin
               si_o = ~si_o;
               #24 sclk_o = 1'b1;
               #24 sclk_o = 1'b0;
            end
            #12 hold_n_o = 1'b1;
         end
         si_o = tx[i];
         #24 rx = {rx[30:0], so_i};
         sclk_o = 1'b1;
         #24 sclk_o = 1'b0;
      end
      #24 cs_n_o = 1'b1;
      // released line: show a value that cannot pass for the last bit
      si_o = ~si_o;
      #48;
   endtask
   // any drive of the output during a frame is remembered
   always @(posedge so_oe_i) oe_seen = 1'b1;
endmodule

// ### verification/spifr_front_bench.sv
// self-checking bench of the serial EEPROM command front
`timescale 1ns/1ps
`include "spifr_consts.svh"
module spifr_front_bench;
   import spifr_pkg::*;
   localparam int WC = 400;
   logic clock_i, resetn_i, ce_i, sclk_i, cs_n_i, si_i, so_o, so_oe_o, hold_n_i;
   logic protect_n_i, hw_lock_o, standby_o, lk, lt, bz, pr;
   spifr_status_t status_o;
   logic [1:0] ps;
   logic [7:0] d;
   logic [15:0] a;
   logic [31:0] rx;
   int n_errors, compares, n, rnd;
   // ********
   // clock, design and host
   // ********
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end
   spifr_front #(.WRITE_CYCLES(WC)) i_dut (.clock_i, .resetn_i, .ce_i, .sclk_i, .cs_n_i,
      .si_i, .so_o, .so_oe_o, .hold_n_i, .protect_n_i, .status_o, .hw_lock_o, .standby_o);
   spifr_host i_host (.so_i(so_o), .so_oe_i(so_oe_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
      .si_o(si_i), .hold_n_o(hold_n_i));
   // ********
   // helpers
   // ********
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // expected status byte, and with standby above it
   function automatic logic [7:0] sb();
      return {lk, 3'h0, ps, lt, bz};
   endfunction
   function automatic logic [8:0] st();
      return {!bz, sb()};
   endfunction
   // the crossing needs a few cycles after deselect
   task automatic cmd(input logic [31:0] tx, input int nb, input int h);
      i_host.xfer(tx, nb, h, rx);
      repeat (6) @(posedge clock_i);
      #1;
   endtask
   // poll busy before the next instruction, with a bound
   task automatic wait_idle();
      int t;
      t = 0;
      while (status_o.busy !== 1'b0 && t < 2 * WC) begin
         @(posedge clock_i);
         t++;
      end
      if (t >= 2 * WC) begin
         n_errors++;
      end
      repeat (6) @(posedge clock_i);
      #1;
   endtask
   task automatic finish_test();
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // hang guard, about four times the expected run
   initial begin
      #300000;
      n_errors++;
      finish_test();
   end
   // ********
   // tests
   // ********
   initial begin
      ce_i = 1'b1;
      protect_n_i = 1'b1;
      resetn_i = 1'b0;
      n_errors = 0;
      compares = 0;
      {lk, lt, bz, ps} = '0;
      rnd = $urandom(51);
      repeat (20) @(posedge clock_i);
      #1 resetn_i = 1'b1;
      chk({so_oe_o, hw_lock_o, standby_o, status_o}, {2'b00, st()});
      cmd(`SPIFR_OP_SET_LATCH, 8, -1);
      chk({standby_o, status_o}, st());
      $display("test power_up done");
      cmd(`SPIFR_OP_SET_LATCH, 8, -1);
      lt = 1'b1;
      chk({standby_o, status_o}, st());
      cmd(`SPIFR_OP_CLR_LATCH, 8, -1);
      lt = 1'b0;
      chk({standby_o, status_o}, st());
      cmd({`SPIFR_OP_STAT_WR, 8'h8C}, 16, -1);
      chk({standby_o, status_o}, st());
      // bit 3 set keeps the opcode outside the defined set
      rnd = $urandom | 32'h08;
      cmd({rnd[7:0], `SPIFR_OP_SET_LATCH, 8'h00}, 24, -1);
      chk({i_host.oe_seen, standby_o, status_o}, {1'b0, st()});
      $display("test latch done");
      // random status writes: good, locked out, short and long frames
      for (int k = 0; k < 6; k++) begin
         d = 8'($urandom);
         if (k == 0) d[7] = 1'b1;
         pr = (k == 1) ? 1'b0 : 1'($urandom);
         // protect pin moves only between operations
         @(posedge clock_i);
         #1 protect_n_i = pr;
         cmd(`SPIFR_OP_SET_LATCH, 8, -1);
         lt = 1'b1;
         cmd({`SPIFR_OP_STAT_RD, 16'h0}, 24, 3 * k);
         chk(rx[15:0], {sb(), sb()});
         chk(hw_lock_o, lk & !pr);
         n = (k == 2) ? 15 : (k == 3) ? 17 : 16;
         cmd({`SPIFR_OP_STAT_WR, d, 1'b0} >> (17 - n), n, -1);
         if (n == 16 && !(lk && !pr)) begin
            bz = 1'b1;
            chk({standby_o, status_o}, st());
            // clock enable low past a whole cycle: the timer must not move
            if (k == 0) begin
               ce_i = 1'b0;
               repeat (WC + 20) @(posedge clock_i);
               #1 ce_i = 1'b1;
               chk({standby_o, status_o}, st());
            end
            wait_idle();
            {bz, lt, lk, ps} = {2'b00, d[7], d[3:2]};
         end
         chk({standby_o, status_o}, st());
      end
      $display("test status_write done");
      @(posedge clock_i);
      #1 protect_n_i = 1'b1;
      // memory write under every protect size: top address for sizes 1 to 3, a random one for size 0
      for (int p = 0; p < 4; p++) begin
         cmd(`SPIFR_OP_SET_LATCH, 8, -1);
         cmd({`SPIFR_OP_STAT_WR, 4'h0, 2'(p), 2'h0}, 16, -1);
         wait_idle();
         {lk, ps, lt} = {1'b0, 2'(p), 1'b0};
         cmd(`SPIFR_OP_SET_LATCH, 8, -1);
         lt = 1'b1;
         a = 16'($urandom);
         if (p != 0) a[14:0] = 15'h7FFF;
         cmd({`SPIFR_OP_MEM_WR, a, 8'($urandom)}, 32, -1);
         bz = (p == 0);
         chk({standby_o, status_o}, st());
         cmd({`SPIFR_OP_STAT_RD, 8'h00}, 16, -1);
         chk({i_host.oe_seen, rx[7:0]}, {1'b1, sb()});
         // memory read: no array behind it, so nothing may drive or change
         cmd({`SPIFR_OP_MEM_RD, a}, 24, -1);
         chk({i_host.oe_seen, standby_o, status_o}, {1'b0, st()});
         wait_idle();
         lt = lt & !bz;
         bz = 1'b0;
         chk({standby_o, status_o}, st());
      end
      $display("test mem_write done");
      finish_test();
   end
endmodule
